/* File: logic/jlhb_ctrl.sv */
// Behaviour
// RULE1: Barrier call links current address plus 6 into chosen register.
// RULE2: Barrier register call with no link specifier links into register 31.
// RULE3: Register target has bit 0 cleared; mode bit loads from source bit 0.
// RULE4: The one delay-slot instruction completes before target fetch.
// RULE5: Software places only 16-bit instructions in short delay slots.
// RULE6: Software never uses the same register as source and link.
// RULE7: With wide set, wide target with address bit 1 set faults on fetch.
// RULE8: Without wide set, source bit 0 clear faults on target fetch.
// RULE9: Barrier clears execution and instruction hazards before target fetch.
// RULE10: Barrier call is accepted in every mode, no privilege needed.
// RULE11: Only hazards older than the barrier jump are drained.
// RULE12: Software keeps jumps, returns and waits out of delay slots.
// RULE13: Software clears instruction hazards after remapping or code writes.
// RULE14: Region target: index shifted left 1, upper bits from slot address.
// RULE15: Region call links current address plus 6 into register 31.
// RULE16: Exchange call links into register 31 with bit 0 as current mode.
// RULE17: Exchange call stays in 256 MB region and switches to wide set.
// RULE18: Fetch is held after the barrier's slot until hazards drain.
`timescale 1ns/1ps

module jlhb_ctrl #(
	parameter bit HAS_WIDE_SET = 1'b1
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_issue,
	input wire jlhb_pkg::jlhb_op_t i_op,
	input wire logic [31:0] i_pc,
	input wire logic [31:0] i_src_val,
	input wire logic [25:0] i_index,
	input wire logic [4:0] i_link_sel,
	input wire logic i_link_omitted,
	input wire logic i_hazard_pending,
	input wire logic i_slot_done,
	input wire logic i_hazard_clear_ack,
	output logic o_busy,
	output logic o_link_we,
	output logic [4:0] o_link_addr,
	output logic [31:0] o_link_data,
	output logic o_fetch_hold,
	output logic o_hazard_clear_req,
	output logic o_redirect,
	output logic [31:0] o_target,
	output logic o_addr_err,
	output logic o_isa_mode
);

	// =====================================================================
	// State
	// =====================================================================
	typedef struct packed
	{
		jlhb_pkg::jlhb_state_t state;
		jlhb_pkg::jlhb_op_t kind;
		logic barrier;
		logic pending;
		logic [31:0] target;
		logic new_mode;
		logic err;
		logic mode;
		logic link_we;
		logic [4:0] link_addr;
		logic [31:0] link_data;
		logic redirect;
	} jlhb_regs_t;

	jlhb_regs_t st;
	jlhb_regs_t next_st;
	logic [31:0] calc_target;
	logic calc_mode;
	logic calc_err;
	logic [4:0] calc_link_addr;
	logic [31:0] calc_link_data;
	logic accept;

	jlhb_target #(
		.HAS_WIDE_SET(HAS_WIDE_SET)
	) u_target (
		.i_op(i_op),
		.i_pc(i_pc),
		.i_src_val(i_src_val),
		.i_index(i_index),
		.i_link_sel(i_link_sel),
		.i_link_omitted(i_link_omitted),
		.i_cur_mode(st.mode),
		.o_target(calc_target),
		.o_new_mode(calc_mode),
		.o_addr_err(calc_err),
		.o_link_addr(calc_link_addr),
		.o_link_data(calc_link_data)
	);

	// =====================================================================
	// Sequencer
	// =====================================================================
	// There is no privilege input at all: the barrier call is refused only while a jump is still in flight.
	assign accept = i_issue && (i_op != jlhb_pkg::JLHB_OP_NONE)
		&& (st.state == jlhb_pkg::JLHB_ST_IDLE); // [RULE10]

	always_comb
	begin
		next_st = st;
		next_st.link_we = 1'b0;
		next_st.redirect = 1'b0;
		unique case (st.state)
			jlhb_pkg::JLHB_ST_IDLE:
			begin
				if (accept)
				begin
					next_st.state = jlhb_pkg::JLHB_ST_SLOT;
					next_st.kind = i_op;
					next_st.barrier =
						(i_op == jlhb_pkg::JLHB_OP_REG_CALL_BARRIER);
					// Sampled once here, so the slot's own hazards are not
					// waited for.
					next_st.pending = i_hazard_pending; // [RULE11]
					next_st.target = calc_target;
					next_st.new_mode = calc_mode;
					next_st.err = calc_err;
					next_st.link_we = 1'b1; // [RULE1] [RULE15] [RULE16]
					next_st.link_addr = calc_link_addr; // [RULE2]
					next_st.link_data = calc_link_data;
				end
			end
			jlhb_pkg::JLHB_ST_SLOT:
			begin
				if (i_slot_done) // [RULE4]
				begin
					if (st.barrier && st.pending)
					begin
						next_st.state = jlhb_pkg::JLHB_ST_DRAIN; // [RULE9]
					end
					else
					begin
						next_st.state = jlhb_pkg::JLHB_ST_REDIR;
					end
				end
			end
			jlhb_pkg::JLHB_ST_DRAIN:
			begin
				if (i_hazard_clear_ack)
				begin
					next_st.state = jlhb_pkg::JLHB_ST_REDIR; // [RULE18]
				end
			end
			jlhb_pkg::JLHB_ST_REDIR:
			begin
				next_st.state = jlhb_pkg::JLHB_ST_IDLE;
				next_st.redirect = 1'b1;
				next_st.mode = st.new_mode; // [RULE3] [RULE17]
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st.state <= jlhb_pkg::JLHB_ST_IDLE;
			st.kind <= jlhb_pkg::JLHB_OP_NONE;
			st.barrier <= 1'b0;
			st.pending <= 1'b0;
			st.target <= jlhb_pkg::JLHB_WORD_RESET;
			st.new_mode <= jlhb_pkg::JLHB_MODE_RESET;
			st.err <= 1'b0;
			st.mode <= jlhb_pkg::JLHB_MODE_RESET;
			st.link_we <= 1'b0;
			st.link_addr <= jlhb_pkg::JLHB_LINK_DEFAULT;
			st.link_data <= jlhb_pkg::JLHB_WORD_RESET;
			st.redirect <= 1'b0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// =====================================================================
	// Outputs
	// =====================================================================
	// Fetch is held from slot end to redirect so no target word sneaks in.
	assign o_busy = (st.state != jlhb_pkg::JLHB_ST_IDLE);
	assign o_fetch_hold = (st.state == jlhb_pkg::JLHB_ST_DRAIN)
		|| (st.state == jlhb_pkg::JLHB_ST_REDIR); // [RULE18]
	assign o_hazard_clear_req = (st.state == jlhb_pkg::JLHB_ST_DRAIN);
	assign o_link_we = st.link_we;
	assign o_link_addr = st.link_addr;
	assign o_link_data = st.link_data;
	assign o_redirect = st.redirect;
	assign o_target = st.target;
	assign o_addr_err = st.redirect && st.err; // [RULE7] [RULE8]
	assign o_isa_mode = st.mode;

	// =====================================================================
	// Checks
	// =====================================================================
	logic [31:0] slot_addr;
	logic slot_seen;

	assign slot_addr = jlhb_pkg::jlhb_add(i_pc, jlhb_pkg::JLHB_SLOT_OFFSET);

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			slot_seen <= 1'b0;
		end
		else if (accept)
		begin
			slot_seen <= 1'b0;
		end
		else if (i_slot_done && st.state == jlhb_pkg::JLHB_ST_SLOT)
		begin
			slot_seen <= 1'b1;
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_barrier_issue;
		accept && i_op == jlhb_pkg::JLHB_OP_REG_CALL_BARRIER;
	endsequence

	sequence s_link_done;
		o_link_we ##0 (st.state == jlhb_pkg::JLHB_ST_SLOT);
	endsequence

	property p_link_addr_plus6;
		s_barrier_issue |=> s_link_done
			##0 (o_link_data == $past(i_pc) + 32'h0000_0006);
	endproperty
	a_link_addr_plus6: assert property (p_link_addr_plus6) // [RULE1]
		else $error("barrier call link value wrong");

	property p_default_link;
		s_barrier_issue ##0 i_link_omitted |=> o_link_addr == 5'h1f;
	endproperty
	a_default_link: assert property (p_default_link) // [RULE2]
		else $error("omitted link did not pick register 31");

	property p_target_bit0;
		o_redirect && st.kind == jlhb_pkg::JLHB_OP_REG_CALL_BARRIER
			|-> !o_target[0];
	endproperty
	a_target_bit0: assert property (p_target_bit0) // [RULE3]
		else $error("register target bit 0 not cleared");

	property p_slot_first;
		o_redirect |-> slot_seen;
	endproperty
	a_slot_first: assert property (p_slot_first) // [RULE4]
		else $error("redirect before delay slot completed");

	property p_wide_misalign;
		s_barrier_issue ##0 (HAS_WIDE_SET && !i_src_val[0] && i_src_val[1])
			|=> st.err;
	endproperty
	a_wide_misalign: assert property (p_wide_misalign) // [RULE7]
		else $error("misaligned wide target not flagged");

	property p_no_wide_fault;
		s_barrier_issue ##0 (!HAS_WIDE_SET && !i_src_val[0]) |=> st.err;
	endproperty
	a_no_wide_fault: assert property (p_no_wide_fault) // [RULE8]
		else $error("wide target without wide set not flagged");

	property p_drain_holds;
		st.state == jlhb_pkg::JLHB_ST_DRAIN && !i_hazard_clear_ack
			|=> o_fetch_hold && !o_redirect && o_hazard_clear_req;
	endproperty
	a_drain_holds: assert property (p_drain_holds) // [RULE9] [RULE18]
		else $error("fetch released before hazards drained");

	property p_old_hazards_only;
		st.state == jlhb_pkg::JLHB_ST_SLOT && i_slot_done && !st.pending
			|=> ##1 o_redirect;
	endproperty
	a_old_hazards_only: assert property (p_old_hazards_only) // [RULE11]
		else $error("drain waited on hazards newer than the jump");

	property p_region_target;
		accept && i_op == jlhb_pkg::JLHB_OP_REGION_CALL
			|=> st.target[26:1] == $past(i_index)
			&& st.target[31:27] == $past(slot_addr[31:27]);
	endproperty
	a_region_target: assert property (p_region_target) // [RULE14]
		else $error("region call target formed wrongly");

	property p_exch_link;
		accept && i_op == jlhb_pkg::JLHB_OP_EXCH_CALL
			|=> o_link_addr == 5'h1f && o_link_data[0] == $past(st.mode);
	endproperty
	a_exch_link: assert property (p_exch_link) // [RULE16]
		else $error("exchange call link wrong");

	property p_exch_mode;
		o_redirect && st.kind == jlhb_pkg::JLHB_OP_EXCH_CALL
			|-> o_isa_mode == 1'b0;
	endproperty
	a_exch_mode: assert property (p_exch_mode) // [RULE17]
		else $error("exchange call did not switch to wide set");

endmodule

/* File: inc/jlhb_pkg.sv */
package jlhb_pkg;

	// =====================================================================
	// Jump kinds presented by decode
	// =====================================================================
	typedef enum logic [1:0]
	{
		JLHB_OP_NONE = 2'h0,
		JLHB_OP_REG_CALL_BARRIER = 2'h1,
		JLHB_OP_REGION_CALL = 2'h2,
		JLHB_OP_EXCH_CALL = 2'h3
	} jlhb_op_t;

	// =====================================================================
	// Sequencer states, Gray coded along idle, slot, drain, redirect
	// =====================================================================
	typedef enum logic [1:0]
	{
		JLHB_ST_IDLE = 2'h0,
		JLHB_ST_SLOT = 2'h1,
		JLHB_ST_DRAIN = 2'h3,
		JLHB_ST_REDIR = 2'h2
	} jlhb_state_t;

	// =====================================================================
	// Address arithmetic and field layout
	// =====================================================================
	localparam logic [31:0] JLHB_SLOT_OFFSET = 32'h0000_0004;
	localparam logic [31:0] JLHB_LINK_OFFSET_SHORT = 32'h0000_0006;
	localparam logic [31:0] JLHB_LINK_OFFSET_EXCH = 32'h0000_0008;
	localparam logic [4:0] JLHB_LINK_DEFAULT = 5'h1f;
	localparam int JLHB_REGION_LSB = 27;
	localparam int JLHB_EXCH_REGION_LSB = 28;
	localparam int JLHB_INDEX_WIDTH = 26;

	// =====================================================================
	// Instruction set mode encoding and reset values
	// =====================================================================
	localparam logic JLHB_MODE_COMPACT = 1'b1;
	localparam logic JLHB_MODE_WIDE = 1'b0;
	localparam logic JLHB_MODE_RESET = 1'b1;
	localparam logic [31:0] JLHB_WORD_RESET = 32'h0000_0000;

	function automatic logic [31:0] jlhb_add(input logic [31:0] a,
		input logic [31:0] b);
	begin
		jlhb_add = a + b;
	end
	endfunction

endpackage

/* File: logic/jlhb_target.sv */
`timescale 1ns/1ps

module jlhb_target #(
	parameter bit HAS_WIDE_SET = 1'b1
) (
	input wire jlhb_pkg::jlhb_op_t i_op,
	input wire logic [31:0] i_pc,
	input wire logic [31:0] i_src_val,
	input wire logic [25:0] i_index,
	input wire logic [4:0] i_link_sel,
	input wire logic i_link_omitted,
	input wire logic i_cur_mode,
	output logic [31:0] o_target,
	output logic o_new_mode,
	output logic o_addr_err,
	output logic [4:0] o_link_addr,
	output logic [31:0] o_link_data
);

	logic [31:0] slot_addr;

	always_comb
	begin
		slot_addr = jlhb_pkg::jlhb_add(i_pc, jlhb_pkg::JLHB_SLOT_OFFSET);
		o_target = {i_src_val[31:1], 1'b0}; // [RULE3]
		o_new_mode = i_cur_mode;
		o_addr_err = 1'b0;
		o_link_addr = jlhb_pkg::JLHB_LINK_DEFAULT;
		o_link_data = jlhb_pkg::jlhb_add(i_pc,
			jlhb_pkg::JLHB_LINK_OFFSET_SHORT); // [RULE1] [RULE15]
		unique case (i_op)
			jlhb_pkg::JLHB_OP_REG_CALL_BARRIER:
			begin
				if (!i_link_omitted)
				begin
					o_link_addr = i_link_sel;
				end
				if (HAS_WIDE_SET)
				begin
					o_new_mode = i_src_val[0]; // [RULE3]
					o_addr_err = !i_src_val[0] && i_src_val[1]; // [RULE7]
				end
				else
				begin
					o_addr_err = !i_src_val[0]; // [RULE8]
				end
			end
			jlhb_pkg::JLHB_OP_REGION_CALL:
			begin
				o_target = {slot_addr[31:jlhb_pkg::JLHB_REGION_LSB],
					i_index, 1'b0}; // [RULE14]
			end
			jlhb_pkg::JLHB_OP_EXCH_CALL:
			begin
				// A wide-set-only target is word aligned by construction.
				o_target = {slot_addr[31:jlhb_pkg::JLHB_EXCH_REGION_LSB],
					i_index, 2'b00}; // [RULE17]
				o_new_mode = jlhb_pkg::JLHB_MODE_WIDE; // [RULE17]
				o_addr_err = !HAS_WIDE_SET;
				o_link_data = jlhb_pkg::jlhb_add(i_pc,
					jlhb_pkg::JLHB_LINK_OFFSET_EXCH);
				o_link_data[0] = i_cur_mode; // [RULE16]
			end
			jlhb_pkg::JLHB_OP_NONE:
			begin
				o_target = {i_src_val[31:1], 1'b0};
			end
		endcase
	end

endmodule

/* File: tb/jlhb_fetch_model.sv */
`timescale 1ns/1ps

// =====================================================================
// Fetch unit and register file stand-in
// =====================================================================
module jlhb_fetch_model (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_link_we,
	input wire logic i_hazard_clear_req,
	input wire logic [3:0] i_slot_delay,
	input wire logic [3:0] i_ack_delay,
	output logic o_slot_done,
	output logic o_hazard_clear_ack
);
	int sc;
	int ac;

	// Drives on the falling edge so the core sees settled pulses.
	// One short, plain instruction per slot, no jump or return.
	// Slot completes only after the link write was seen.
	// The drain is acknowledged only while it is requested.
	always @(negedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_slot_done <= 1'b0;
			o_hazard_clear_ack <= 1'b0;
			sc <= 0;
			ac <= 0;
		end
		else
		begin
			o_slot_done <= (sc == 1);
			sc <= i_link_we ? int'(i_slot_delay) + 1 : (sc > 0 ? sc - 1 : 0);
			ac <= i_hazard_clear_req ? ac + 1 : 0;
			o_hazard_clear_ack <= i_hazard_clear_req && ac == int'(i_ack_delay);
		end
	end
endmodule

/* File: tb/jump_link_hazard_barrier_bench.sv */
`timescale 1ns/1ps

module jump_link_hazard_barrier_bench;
	// =================================================================
	// Stimulus, expectations and counters
	// =================================================================
	logic i_core_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_issue = 1'b0;
	jlhb_pkg::jlhb_op_t i_op = jlhb_pkg::JLHB_OP_NONE;
	logic [31:0] i_pc = 32'h0000_0000;
	logic [31:0] i_src_val = 32'h0000_0000;
	logic [25:0] i_index = 26'h000_0000;
	logic [4:0] i_link_sel = 5'h00;
	logic i_link_omitted = 1'b0;
	logic i_hazard_pending = 1'b0;
	logic [3:0] slot_dly = 4'h0;
	logic [3:0] ack_dly = 4'h0;
	logic i_slot_done, i_hazard_clear_ack, o_busy, o_link_we, o_fetch_hold;
	logic o_hazard_clear_req, o_redirect, o_addr_err, o_isa_mode;
	logic [4:0] o_link_addr;
	logic [31:0] o_link_data, o_target, e_data, e_tgt, r1, r2, r3, r4;
	logic [4:0] e_addr;
	logic e_err, e_mode, e_pend, e_nerr, n_redir, n_err, done;
	logic m = 1'b1;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int t_slot = 0;
	int t_ack = 0;
	int n_we = 0;
	int n_job = 0;
	integer seed = 32'h0000_03b7;

	initial forever #5 i_core_clk = ~i_core_clk;

	jlhb_ctrl #(.HAS_WIDE_SET(1'b1)) dut (.i_core_clk(i_core_clk),
		.i_rstn(i_rstn), .i_issue(i_issue), .i_op(i_op), .i_pc(i_pc),
		.i_src_val(i_src_val), .i_index(i_index), .i_link_sel(i_link_sel),
		.i_link_omitted(i_link_omitted), .i_hazard_pending(i_hazard_pending),
		.i_slot_done(i_slot_done), .i_hazard_clear_ack(i_hazard_clear_ack),
		.o_busy(o_busy), .o_link_we(o_link_we), .o_link_addr(o_link_addr),
		.o_link_data(o_link_data), .o_fetch_hold(o_fetch_hold),
		.o_hazard_clear_req(o_hazard_clear_req), .o_redirect(o_redirect),
		.o_target(o_target), .o_addr_err(o_addr_err),
		.o_isa_mode(o_isa_mode));

	jlhb_fetch_model partner (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
		.i_link_we(o_link_we), .i_hazard_clear_req(o_hazard_clear_req),
		.i_slot_delay(slot_dly), .i_ack_delay(ack_dly),
		.o_slot_done(i_slot_done), .o_hazard_clear_ack(i_hazard_clear_ack));

	// Same stimulus into a build without the wide set; its sequencing
	// matches the main instance, so it can share the fetch stand-in.
	jlhb_ctrl #(.HAS_WIDE_SET(1'b0)) dut_narrow (.i_core_clk(i_core_clk),
		.i_rstn(i_rstn), .i_issue(i_issue), .i_op(i_op), .i_pc(i_pc),
		.i_src_val(i_src_val), .i_index(i_index), .i_link_sel(i_link_sel),
		.i_link_omitted(i_link_omitted), .i_hazard_pending(i_hazard_pending),
		.i_slot_done(i_slot_done), .i_hazard_clear_ack(i_hazard_clear_ack),
		.o_busy(), .o_link_we(), .o_link_addr(), .o_link_data(),
		.o_fetch_hold(), .o_hazard_clear_req(), .o_redirect(n_redir),
		.o_target(), .o_addr_err(n_err), .o_isa_mode());

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// =================================================================
	// Monitor, on the falling edge where outputs have settled
	// =================================================================
	always @(posedge i_core_clk) cyc <= cyc + 1;

	always @(negedge i_core_clk)
	begin
		if (i_slot_done)
		begin
			t_slot = cyc;
			check(32'({o_busy, o_fetch_hold}), 32'h0000_0003);
			check(32'(o_hazard_clear_req), 32'(e_pend));
		end
		if (i_hazard_clear_ack)
			t_ack = cyc;
		if (o_link_we)
		begin
			n_we++;
			check(32'(o_link_addr), 32'(e_addr));
			check(o_link_data, e_data);
			check(o_target, e_tgt);
		end
		if (o_redirect)
		begin
			// The core samples this redirect at the next rising edge.
			check(cyc + 1, (e_pend ? t_ack : t_slot) + 2);
			check(32'({o_busy, o_fetch_hold}), 32'h0000_0000);
			check(32'(o_isa_mode), 32'(e_mode));
			check(32'(o_addr_err), 32'(e_err));
			check(32'({n_redir, n_err}), 32'({1'b1, e_nerr}));
			done = 1'b1;
		end
	end

	// =================================================================
	// One jump, with the reference model worked out up front
	// =================================================================
	task automatic jump(input jlhb_pkg::jlhb_op_t op, input logic [31:0] pc,
		input logic [31:0] src, input logic [25:0] idx, input logic [4:0] sel,
		input logic omit, input logic pend, input logic poke);
		logic [31:0] s;
		logic [31:0] p8;
		int k;
		s = pc + 32'h0000_0004;
		p8 = pc + 32'h0000_0008;
		e_addr = (op != jlhb_pkg::JLHB_OP_REG_CALL_BARRIER || omit) ? 5'h1f : sel;
		e_data = op == jlhb_pkg::JLHB_OP_EXCH_CALL ? {p8[31:1], m} :
			pc + 32'h0000_0006;
		e_tgt = op == jlhb_pkg::JLHB_OP_REGION_CALL ? {s[31:27], idx, 1'b0} :
			op == jlhb_pkg::JLHB_OP_EXCH_CALL ? {s[31:28], idx, 2'b00} :
			{src[31:1], 1'b0};
		e_mode = op == jlhb_pkg::JLHB_OP_REG_CALL_BARRIER ? src[0] :
			op == jlhb_pkg::JLHB_OP_EXCH_CALL ? 1'b0 : m;
		e_err = op == jlhb_pkg::JLHB_OP_REG_CALL_BARRIER && !src[0] && src[1];
		e_nerr = (op == jlhb_pkg::JLHB_OP_EXCH_CALL)
			|| (op == jlhb_pkg::JLHB_OP_REG_CALL_BARRIER && !src[0]);
		e_pend = op == jlhb_pkg::JLHB_OP_REG_CALL_BARRIER && pend;
		done = 1'b0;
		n_job++;
		// Source and link register numbers are never the same here.
		i_issue = 1'b1;
		i_op = op;
		i_pc = pc;
		i_src_val = src;
		i_index = idx;
		i_link_sel = sel;
		i_link_omitted = omit;
		i_hazard_pending = pend;
		@(negedge i_core_clk);
		i_issue = poke;
		@(negedge i_core_clk);
		i_issue = 1'b0;
		for (k = 0; k < 60 && !done; k++)
			@(negedge i_core_clk);
		if (!done)
		begin
			fails++;
			$display("unexpected at %0t: no redirect", $time);
		end
		m = e_mode;
		check(n_we, n_job);
		$display("jump %0d done", n_job);
	endtask

	// =================================================================
	// Main sequence
	// =================================================================
	initial
	begin
		repeat (5) @(posedge i_core_clk);
		@(negedge i_core_clk);
		i_rstn = 1'b1;
		jump(jlhb_pkg::JLHB_OP_REG_CALL_BARRIER, 32'h1000_0100, 32'h2000_0041,
			26'h000_0000, 5'h04, 1'b1, 1'b1, 1'b0);
		slot_dly = 4'h2;
		ack_dly = 4'h3;
		jump(jlhb_pkg::JLHB_OP_REG_CALL_BARRIER, 32'h1000_0200, 32'h2000_0012,
			26'h000_0000, 5'h09, 1'b0, 1'b1, 1'b1);
		jump(jlhb_pkg::JLHB_OP_REGION_CALL, 32'h17ff_fffc, 32'h0000_0000,
			26'h3ff_ffff, 5'h00, 1'b0, 1'b1, 1'b0);
		jump(jlhb_pkg::JLHB_OP_EXCH_CALL, 32'h0fff_fffc, 32'h0000_0000,
			26'h155_5555, 5'h00, 1'b0, 1'b0, 1'b1);
		i_issue = 1'b1;
		i_op = jlhb_pkg::JLHB_OP_NONE;
		repeat (3) @(negedge i_core_clk);
		i_issue = 1'b0;
		check(n_we, n_job);
		$display("idle issue test done");
		for (int i = 0; i < 40; i++)
		begin
			r1 = $random(seed);
			r2 = $random(seed);
			r3 = $random(seed);
			r4 = $random(seed);
			slot_dly = r4[3:0];
			ack_dly = r4[9:6];
			jump(r4[5:4] == 2'h0 ? jlhb_pkg::JLHB_OP_REG_CALL_BARRIER :
				jlhb_pkg::jlhb_op_t'(r4[5:4]), r1, r2, r3[25:0], r3[30:26],
				r3[31], r4[10], r4[11]);
		end
		wrap_up;
	end

	initial
	begin
		#400000;
		fails++;
		wrap_up;
	end
endmodule
